// file: hw/qws_pkg.sv
// Shared constants and carriers for the quad waveform sequencer.
// Assumes a single sample clock; all registers sit on one byte-addressed port.
package qws_pkg;
    // Register byte offsets
    localparam logic [15:0] REG_STATE = 16'h0000;
    localparam logic [15:0] REG_XFER = 16'h0004;
    localparam logic [15:0] REG_TBASE = 16'h0008;
    localparam logic [15:0] REG_PERIOD = 16'h000c;
    localparam logic [15:0] REG_RTYPE = 16'h0010;
    localparam logic [15:0] REG_TRIGDLY = 16'h0014;
    localparam logic [15:0] REG_TUNING = 16'h0018;
    localparam logic [15:0] REG_CH_BASE = 16'h0040;
    localparam logic [1:0] MEM_SEL = 2'h1;
    // Field positions
    localparam int ST_ARM = 0;
    localparam int ST_ACT = 1;
    localparam int CH_EDGE = 8;
    localparam int CH_CONT = 4;
    // Reset values and limits
    localparam logic [4:0] PER_LSB_RST = 5'h10;
    localparam logic [4:0] PER_LSB_MAX = 5'h10;
    localparam logic [11:0] GAIN_UNITY = 12'h400;
    localparam logic [11:0] LFSR_SEED = 12'h001;

    typedef enum logic [2:0] {
        SRC_SAW, SRC_PRN, SRC_DC, SRC_SINE, SRC_MEM, SRC_AM
    } qws_src_type;

    typedef struct packed {
        logic [11:0] first;
        logic [11:0] last;
        logic [15:0] onset;
        logic [11:0] gain;
        logic [11:0] offset;
        logic [11:0] konst;
        logic [11:0] phase;
        logic [7:0] rpt;
        logic [7:0] cyc;
        logic [2:0] src;
        logic cont;
        logic edgeSel;
    } qws_chan_type;

    typedef struct packed {
        logic [4:0] perLsb;
        logic [7:0] onsBase;
        logic [15:0] period;
        logic finite;
        logic [15:0] trigDly;
        logic [23:0] tuning;
    } qws_glob_type;
endpackage : qws_pkg

// file: hw/qws_sequencer.sv
// Quad waveform sequencer: pattern state machine, DDS, sample memory and
// four channel data paths with gain, offset and saturation.
// Assumes trigger arrives asynchronously and the register master never waits.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
// Function
// - Continuous, endless pulse train, finite pulse train
// - Arm bit arms; clearing it shuts down
// - Falling trigger starts only while armed
// - Active state follows programmed trigger delay
// - Rising trigger edge requests stop
// - Activity bit reads one while active
// - Continuous channels run through whole active state
// - Pulse train once per back-to-back period
// - Finite mode outputs exactly repeat-count periods
// - Per-channel onset delay from each period start
// - Period equals length times clocks per LSB
// - Onset timebase sets clocks per delay LSB
// - Four channels read memory simultaneously
// - Signed 12-bit gain spanning plus/minus two
// - Add 12-bit offset after gain
// - Six-way source selector per channel
// - AM multiplies DDS by memory sample
// - Sine burst width counted in cycles
// - Per-channel phase offset on shared DDS
// - Per-channel output clock edge select
// - Address runs first to last address
// - Memory access only while disarmed
// - Shadow copy to active when idle
module qws_sequencer
    import qws_pkg::*;
#(
    parameter int NCH = 4,
    parameter int MEM_DEPTH = 4096
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Trigger
    input wire logic trigIn,
    // Converter channels
    output logic [NCH*12-1:0] dacCode,
    output logic [NCH-1:0] dacInvClk,
    output logic active
);
    typedef enum {IDLE, DELAY, ACTIVE} qws_state_type;
    qws_state_type state;
    qws_chan_type shCh [NCH];
    qws_chan_type acCh [NCH];
    qws_glob_type shGl, acGl;
    logic armQ, xferPendQ;
    logic [31:0] rdataQ;
    logic [11:0] mem [MEM_DEPTH];
    logic s1Q, s2Q, s3Q;
    logic [15:0] dlyCntQ;
    logic [4:0] tickCntQ;
    logic [15:0] perCntQ;
    logic [7:0] onsCntQ;
    logic [23:0] ddsAccQ;
    logic trigFall, trigRise, perTick, onsTick, periodStart, xferNow;
    logic memHit;
    logic [11:0] memIdx;

    // Channel index of a per-channel register, or NCH when not one
    function automatic int chOf(input logic [15:0] a);
        int r;
        r = NCH;
        if (a >= REG_CH_BASE && a < REG_CH_BASE + 16'(NCH*32)) begin
            r = int'((a - REG_CH_BASE) >> 5);
        end
        return r;
    endfunction : chOf

    // Clamp a wide signed sum into the signed 12-bit code range
    function automatic logic [11:0] sat12(input logic signed [15:0] v);
        if (v > 16'sd2047) begin
            return 12'h7ff;
        end else if (v < -16'sd2048) begin
            return 12'h800;
        end
        return v[11:0];
    endfunction : sat12

    // Parabolic sine approximation; cheap, slightly higher harmonics than a table
    function automatic logic [11:0] sine12(input logic [11:0] ph);
        logic [10:0] x;
        logic [21:0] p;
        logic [11:0] m;
        x = ph[10:0];
        p = 22'(x) * 22'(11'h7ff - x);
        m = {1'b0, p[20:10]};
        return ph[11] ? 12'(-m) : m;
    endfunction : sine12

    assign memHit = regAddr[15:14] == MEM_SEL;
    assign memIdx = regAddr[13:2];
    assign regRdata = rdataQ;
    assign active = state == ACTIVE;
    assign xferNow = xferPendQ && state == IDLE;

    // Trigger synchroniser; s1Q feeds only s2Q
    always_ff @(posedge clk) begin
        if (rst) begin
            s1Q <= 1'b1;
            s2Q <= 1'b1;
            s3Q <= 1'b1;
        end else begin
            s1Q <= trigIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
        end
    end
    assign trigFall = s3Q && !s2Q;
    assign trigRise = !s3Q && s2Q;

    // Control and shadow register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            armQ <= 1'b0;
            xferPendQ <= 1'b0;
            shGl <= '{perLsb: PER_LSB_RST, onsBase: 8'h01, default: '0};
            for (int i = 0; i < NCH; i++) begin
                shCh[i] <= '{gain: GAIN_UNITY, default: '0};
            end
        end else begin
            // A write landing on the copy cycle keeps the request pending
            if (regWr && regAddr == REG_XFER && regWdata[0]) begin
                xferPendQ <= 1'b1;
            end else if (xferNow) begin
                xferPendQ <= 1'b0;
            end
            if (regWr) begin
                case (regAddr)
                    REG_STATE: armQ <= regWdata[ST_ARM];
                    REG_TBASE: begin
                        shGl.perLsb <= (regWdata[4:0] > PER_LSB_MAX) ? PER_LSB_MAX
                                     : regWdata[4:0];
                        shGl.onsBase <= regWdata[15:8];
                    end
                    REG_PERIOD: shGl.period <= regWdata[15:0];
                    REG_RTYPE: shGl.finite <= regWdata[0];
                    REG_TRIGDLY: shGl.trigDly <= regWdata[15:0];
                    REG_TUNING: shGl.tuning <= regWdata[23:0];
                    default: begin
                        if (chOf(regAddr) < NCH) begin
                            case (regAddr[4:2])
                                3'h0: shCh[chOf(regAddr)].first <= regWdata[11:0];
                                3'h1: shCh[chOf(regAddr)].last <= regWdata[11:0];
                                3'h2: shCh[chOf(regAddr)].onset <= regWdata[15:0];
                                3'h3: shCh[chOf(regAddr)].gain <= regWdata[11:0];
                                3'h4: shCh[chOf(regAddr)].offset <= regWdata[11:0];
                                3'h5: begin
                                    shCh[chOf(regAddr)].src <= regWdata[2:0];
                                    shCh[chOf(regAddr)].cont <= regWdata[CH_CONT];
                                    shCh[chOf(regAddr)].edgeSel <= regWdata[CH_EDGE];
                                end
                                3'h6: begin
                                    shCh[chOf(regAddr)].rpt <= regWdata[7:0];
                                    shCh[chOf(regAddr)].cyc <= regWdata[15:8];
                                end
                                default: begin
                                    shCh[chOf(regAddr)].phase <= regWdata[11:0];
                                    shCh[chOf(regAddr)].konst <= regWdata[27:16];
                                end
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // Shadow to active copy; only while the pattern is off
    always_ff @(posedge clk) begin
        if (rst) begin
            acGl <= '{perLsb: PER_LSB_RST, onsBase: 8'h01, default: '0};
            for (int i = 0; i < NCH; i++) begin
                acCh[i] <= '{gain: GAIN_UNITY, default: '0};
            end
        end else if (xferNow) begin
            acGl <= shGl;
            acCh <= shCh;
        end
    end

    // Sample memory host access, locked out while armed
    always_ff @(posedge clk) begin
        if (regWr && memHit && !armQ) begin
            mem[memIdx] <= regWdata[11:0];
        end
    end

    // Read path; unmapped addresses and locked memory read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdataQ <= 32'h0;
        end else if (regRd) begin
            rdataQ <= 32'h0;
            if (memHit) begin
                if (!armQ) begin
                    rdataQ <= {20'h0, mem[memIdx]};
                end
            end else if (regAddr == REG_STATE) begin
                rdataQ[ST_ARM] <= armQ;
                rdataQ[ST_ACT] <= state == ACTIVE;
            end else if (regAddr == REG_XFER) begin
                rdataQ[0] <= xferPendQ;
            end else if (regAddr == REG_PERIOD) begin
                rdataQ[15:0] <= shGl.period;
            end else if (regAddr == REG_TRIGDLY) begin
                rdataQ[15:0] <= shGl.trigDly;
            end
        end
    end

    // Pattern state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IDLE;
            dlyCntQ <= 16'h0;
        end else if (!armQ) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    if (trigFall) begin
                        state <= DELAY;
                        dlyCntQ <= 16'h0;
                    end
                end
                DELAY: begin
                    if (trigRise) begin
                        state <= IDLE;
                    end else if (dlyCntQ + 16'h1 >= acGl.trigDly) begin
                        state <= ACTIVE;
                    end else begin
                        dlyCntQ <= dlyCntQ + 16'h1;
                    end
                end
                ACTIVE: begin
                    if (trigRise) begin
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // Period and onset timebases; periods follow back to back
    assign perTick = tickCntQ + 5'h1 >= acGl.perLsb;
    assign onsTick = onsCntQ + 8'h1 >= acGl.onsBase;
    assign periodStart = (state == DELAY && dlyCntQ + 16'h1 >= acGl.trigDly && !trigRise)
                      || (state == ACTIVE && perTick && perCntQ + 16'h1 >= acGl.period);
    always_ff @(posedge clk) begin
        if (rst || state != ACTIVE) begin
            tickCntQ <= 5'h0;
            perCntQ <= 16'h0;
        end else if (perTick) begin
            tickCntQ <= 5'h0;
            perCntQ <= (perCntQ + 16'h1 >= acGl.period) ? 16'h0 : perCntQ + 16'h1;
        end else begin
            tickCntQ <= tickCntQ + 5'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || periodStart || state != ACTIVE) begin
            onsCntQ <= 8'h0;
        end else begin
            onsCntQ <= onsTick ? 8'h0 : onsCntQ + 8'h1;
        end
    end

    // Shared DDS phase accumulator
    always_ff @(posedge clk) begin
        if (rst || state == IDLE) begin
            ddsAccQ <= 24'h0;
        end else begin
            ddsAccQ <= ddsAccQ + acGl.tuning;
        end
    end

    // Four channel data paths
    for (genvar c = 0; c < NCH; c++) begin : gCh
        qws_chan_type cf;
        logic runQ, waitQ, prevMsbQ;
        logic [11:0] addrQ, memQ, sawQ, lfsrQ, sampQ, codeQ;
        logic [15:0] onsQ;
        logic [7:0] doneQ, cycQ;
        logic [11:0] ph, sn, raw;
        logic [23:0] amProd, gProd;
        logic signed [15:0] sum;
        logic emit, wrap, isSine;
        assign cf = acCh[c];
        assign ph = ddsAccQ[23:12] + cf.phase;
        assign sn = sine12(ph);
        assign wrap = prevMsbQ && !ph[11];
        assign isSine = cf.src == SRC_SINE || cf.src == SRC_AM;
        assign emit = cf.cont ? state == ACTIVE : runQ;

        // Sequencing within each period; the first period starts on the DELAY exit edge
        always_ff @(posedge clk) begin
            if (rst || (state != ACTIVE && !periodStart)) begin
                runQ <= 1'b0;
                waitQ <= 1'b0;
                onsQ <= 16'h0;
                doneQ <= 8'h0;
                cycQ <= 8'h0;
                addrQ <= cf.first;
            end else if (periodStart) begin
                runQ <= 1'b0;
                onsQ <= 16'h0;
                waitQ <= !(acGl.finite && doneQ >= cf.rpt);
                if (!cf.cont) begin
                    addrQ <= cf.first;
                end
            end else if (waitQ && onsQ >= cf.onset) begin
                waitQ <= 1'b0;
                runQ <= 1'b1;
                cycQ <= cf.cyc;
                doneQ <= doneQ + 8'h1;
            end else if (waitQ && onsTick) begin
                onsQ <= onsQ + 16'h1;
            end else if (runQ && isSine && !cf.cont) begin
                if (wrap) begin
                    cycQ <= cycQ - 8'h1;
                    runQ <= cycQ > 8'h1;
                end
            end
            if (state == ACTIVE && !periodStart && (runQ || cf.cont)) begin
                // Continuous channels wrap; pulse channels stop at the end unless sine or AM sourced
                if (addrQ == cf.last) begin
                    addrQ <= cf.first;
                    if (!cf.cont && !isSine) begin
                        runQ <= 1'b0;
                    end
                end else begin
                    addrQ <= addrQ + 12'h1;
                end
            end
        end

        // Simultaneous memory read and local generators
        always_ff @(posedge clk) begin
            if (rst) begin
                memQ <= 12'h0;
                sawQ <= 12'h0;
                lfsrQ <= LFSR_SEED;
                prevMsbQ <= 1'b0;
            end else begin
                memQ <= mem[addrQ];
                prevMsbQ <= ph[11];
                if (emit) begin
                    sawQ <= sawQ + 12'h1;
                    lfsrQ <= {lfsrQ[10:0], lfsrQ[11] ^ lfsrQ[10] ^ lfsrQ[9] ^ lfsrQ[3]};
                end
            end
        end

        // Source selection
        assign amProd = 24'($signed(sn) * $signed(memQ));
        always_comb begin
            case (cf.src)
                SRC_SAW: raw = sawQ;
                SRC_PRN: raw = lfsrQ;
                SRC_DC: raw = cf.konst;
                SRC_SINE: raw = sn;
                SRC_MEM: raw = memQ;
                SRC_AM: raw = amProd[22:11];
                default: raw = 12'h0;
            endcase
        end
        // Gain 1024 is unity, so the signed 12-bit factor spans plus/minus two
        assign gProd = 24'($signed(emit ? raw : 12'h0) * $signed(cf.gain));
        assign sum = 16'($signed(gProd[23:10])) + 16'($signed(cf.offset));
        always_ff @(posedge clk) begin
            if (rst) begin
                sampQ <= 12'h0;
                codeQ <= 12'h800;
            end else begin
                sampQ <= sat12(sum);
                codeQ <= sampQ ^ 12'h800;
            end
        end
        assign dacCode[c*12 +: 12] = codeQ;
        assign dacInvClk[c] = cf.edgeSel;
    end

    // Checks
    property p_noStartDisarmed;
        @(posedge clk) disable iff (rst) state == IDLE && trigFall && !armQ |=> state == IDLE;
    endproperty
    a_noStartDisarmed: assert property (p_noStartDisarmed) else $error("started disarmed");
    property p_startArmed;
        @(posedge clk) disable iff (rst) state == IDLE && trigFall && armQ |=> state == DELAY;
    endproperty
    a_startArmed: assert property (p_startArmed) else $error("armed start missed");
    property p_stop;
        @(posedge clk) disable iff (rst) state == ACTIVE && trigRise |=> state == IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("stop request ignored");
    property p_disarm;
        @(posedge clk) disable iff (rst) !armQ |=> state == IDLE;
    endproperty
    a_disarm: assert property (p_disarm) else $error("not shut down");
    property p_actBit;
        @(posedge clk) disable iff (rst)
            regRd && regAddr == REG_STATE |=> rdataQ[ST_ACT] == $past(state == ACTIVE);
    endproperty
    a_actBit: assert property (p_actBit) else $error("activity bit wrong");
    property p_memLock;
        @(posedge clk) disable iff (rst) regRd && memHit && armQ |=> rdataQ == 32'h0;
    endproperty
    a_memLock: assert property (p_memLock) else $error("memory read while armed");
    property p_xfer;
        @(posedge clk) disable iff (rst) xferNow && !regWr |=> acGl == $past(shGl) && !xferPendQ;
    endproperty
    a_xfer: assert property (p_xfer) else $error("shadow copy missing");
    property p_sync;
        @(posedge clk) disable iff (rst) trigFall |-> $past(trigIn, 3) && !$past(trigIn, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("trigger edge not synchronised");
    c_active: cover property (@(posedge clk) disable iff (rst) state == DELAY ##1 state == ACTIVE);
    c_stop: cover property (@(posedge clk) disable iff (rst) state == ACTIVE ##1 state == IDLE);
    c_period: cover property (@(posedge clk) disable iff (rst) state == ACTIVE && periodStart);
endmodule : qws_sequencer

// file: bench/qws_far_end.sv
// Far-end model: trigger source and four converters watching the codes.
// Assumes one sample clock; the bench asks for trigger levels, idle high.
`timescale 1ns/1ns
module qws_far_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Trigger request and line
    input wire logic trigWant,
    output logic trigIn = 1'b1,
    // Converter inputs and latched codes
    input wire logic [47:0] dacCode,
    input wire logic [3:0] dacInvClk,
    output logic [11:0] heldCode [4]
);
    logic [1:0] holdCnt = 2'h0;
    // Each level stands three cycles at least, so the sampler sees every edge
    always @(posedge clk) begin
        if (rst) begin
            trigIn <= 1'b1;
            holdCnt <= 2'h0;
        end else if (holdCnt != 2'h0) begin
            holdCnt <= holdCnt - 2'h1;
        end else if (trigWant !== trigIn) begin
            trigIn <= trigWant;
            holdCnt <= 2'h2;
        end
    end
    // Converters latch on the edge their select asks for
    for (genvar c = 0; c < 4; c++) begin : g_conv
        always @(posedge clk or negedge clk) begin
            if (clk !== dacInvClk[c]) heldCode[c] <= dacCode[c*12+:12];
        end
    end
endmodule : qws_far_end

// file: bench/testbench.sv
// Self-checking bench for the quad waveform sequencer.
// Assumes the far-end model drives the trigger and latches converter codes.
`timescale 1ns/1ns
module testbench;
    import qws_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic trigWant = 1'b1;
    logic trigIn;
    logic [47:0] dacCode;
    logic [3:0] dacInvClk;
    logic active;
    logic [11:0] heldCode [4];
    int st [4][$];
    int error_cnt = 0;
    int n_checks = 0;

    // 25 MHz sample clock
    initial begin
        forever #20 clk = ~clk;
    end

    qws_sequencer u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .trigIn(trigIn),
        .dacCode(dacCode), .dacInvClk(dacInvClk), .active(active));
    qws_far_end u_far (.clk(clk), .rst(rst), .trigWant(trigWant), .trigIn(trigIn),
        .dacCode(dacCode), .dacInvClk(dacInvClk), .heldCode(heldCode));

    task automatic test_done();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic fail(input string m);
        error_cnt++;
        $display("MISMATCH %0t %s", $time, m);
        test_done();
    endtask : fail

    // Bus cycles start on a fresh edge so a strobe is never set twice in one step
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk({16'h0, d}, {16'h0, e});
    endtask : rdChk

    task automatic trig(input logic lvl);
        @(posedge clk);
        trigWant <= lvl;
    endtask : trig

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Shadow copy only happens while idle; pending must clear quickly
    task automatic xfer();
        logic [31:0] d;
        wr(REG_XFER, 32'h1);
        for (int i = 0; i < 20; i++) begin
            rd(REG_XFER, d);
            if (d[0] === 1'b0) return;
        end
        fail("transfer stuck");
    endtask : xfer

    task automatic waitAct(input logic lvl, input int lim, output int n);
        n = 0;
        #1;
        while (active !== lvl) begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim) fail("activity wait");
        end
    endtask : waitAct

    task automatic cfg(input int c, input logic [31:0] w0, w1, w2, w3, w4, w5, w6, w7);
        logic [31:0] w [8];
        w = '{w0, w1, w2, w3, w4, w5, w6, w7};
        for (int k = 0; k < 8; k++) wr(REG_CH_BASE + 16'(c * 32 + k * 4), w[k]);
    endtask : cfg

    task automatic resetVals();
        rdChk(REG_STATE, 32'h0);
        rdChk(REG_TBASE, 32'h0);
        rdChk(16'h3000, 32'h0);
        chk(dacCode, {4{12'h800}});
    endtask : resetVals

    // Sample memory is reachable only while disarmed
    task automatic memAccess();
        for (int i = 0; i < 4; i++) wr(16'h4000 + 16'(4 * i), 32'(i + 1) << 8);
        rdChk(16'h4004, 32'h200);
        wr(REG_STATE, 32'h1);
        wr(16'h4000, 32'h555);
        rdChk(16'h4000, 32'h0);
        wr(REG_STATE, 32'h0);
        rdChk(16'h4000, 32'h100);
    endtask : memAccess

    task automatic dcPath();
        int n;
        cfg(0, 0, 0, 0, 32'h400, 32'h010, 32'h12, 0, 32'h01000000);
        cfg(1, 0, 0, 0, 32'he00, 32'h000, 32'h112, 0, 32'h01000000);
        cfg(2, 0, 0, 0, 32'h7ff, 32'h7ff, 32'h12, 0, 32'h07ff0000);
        cfg(3, 0, 0, 0, 32'h400, 32'h800, 32'h12, 0, 32'h08000000);
        xfer();
        cyc(4);
        chk(dacInvClk, 48'h2);
        chk(dacCode, {12'h000, 12'hfff, 12'h800, 12'h810});
        trig(1'b0);
        cyc(20);
        chk(active, 48'h0);
        trig(1'b1);
        cyc(4);
        wr(REG_STATE, 32'h1);
        trig(1'b0);
        waitAct(1'b1, 60, n);
        cyc(6);
        #1;
        chk(dacCode, {12'h000, 12'hfff, 12'h780, 12'h910});
        chk(heldCode[1], 48'h780);
        rdChk(REG_STATE, 32'h3);
        trig(1'b1);
        waitAct(1'b0, 10, n);
        rdChk(REG_STATE, 32'h1);
        wr(REG_STATE, 32'h0);
    endtask : dcPath

    task automatic trigDelay();
        int n1;
        int n2;
        int n;
        wr(REG_TRIGDLY, 32'd5);
        xfer();
        wr(REG_STATE, 32'h1);
        trig(1'b0);
        waitAct(1'b1, 60, n1);
        trig(1'b1);
        waitAct(1'b0, 10, n);
        wr(REG_TRIGDLY, 32'd12);
        xfer();
        trig(1'b0);
        waitAct(1'b1, 60, n2);
        chk(48'(n2 - n1), 48'd7);
        wr(REG_STATE, 32'h0);
        waitAct(1'b0, 4, n);
        trig(1'b1);
    endtask : trigDelay

    // Record pulse starts per channel and count channel 2's emitting cycles
    task automatic scan(output int cnt2, output logic [11:0] c3);
        logic nz;
        logic [3:0] prev;
        prev = 4'h0;
        cnt2 = 0;
        c3 = 12'h800;
        for (int c = 0; c < 4; c++) st[c].delete();
        for (int k = 0; k < 240; k++) begin
            @(posedge clk);
            #1;
            for (int c = 0; c < 4; c++) begin
                nz = dacCode[c*12+:12] !== 12'h800;
                if (nz && !prev[c]) st[c].push_back(k);
                if (nz && !prev[c] && c == 3 && st[3].size() == 1) c3 = dacCode[47:36];
                if (nz && c == 2) cnt2++;
                prev[c] = nz;
            end
        end
    endtask : scan

    task automatic pattern();
        int n;
        int cnt;
        logic [11:0] c3;
        cfg(0, 0, 1, 0, 32'h400, 0, 32'h4, 32'hff, 0);
        cfg(1, 0, 1, 3, 32'h400, 0, 32'h4, 32'hff, 0);
        cfg(2, 0, 3, 0, 32'h400, 0, 32'h4, 32'h02, 0);
        cfg(3, 2, 3, 0, 32'h400, 0, 32'h4, 32'hff, 0);
        wr(REG_TBASE, 32'h0204);
        wr(REG_PERIOD, 32'd10);
        wr(REG_RTYPE, 32'h1);
        xfer();
        wr(REG_STATE, 32'h1);
        trig(1'b0);
        waitAct(1'b1, 60, n);
        scan(cnt, c3);
        chk(48'(st[1][0] - st[0][0]), 48'd6);
        chk(48'(st[3][0] - st[0][0]), 48'd0);
        chk(48'(st[0][1] - st[0][0]), 48'd40);
        chk(c3, 48'hb00);
        chk(48'(cnt), 48'd8);
        trig(1'b1);
        waitAct(1'b0, 10, n);
        wr(REG_RTYPE, 32'h0);
        xfer();
        trig(1'b0);
        waitAct(1'b1, 60, n);
        scan(cnt, c3);
        chk(cnt > 8, 48'h1);
        trig(1'b1);
        waitAct(1'b0, 10, n);
    endtask : pattern

    // Two-cycle sine bursts on channel 2; a 16-clock DDS in a 32-clock period
    task automatic sineBurst();
        int n;
        int cnt;
        logic [11:0] c3;
        cfg(2, 0, 0, 0, 32'h400, 0, 32'h3, 32'h0202, 0);
        wr(REG_TUNING, 32'h100000);
        wr(REG_PERIOD, 32'd8);
        wr(REG_RTYPE, 32'h1);
        rdChk(REG_PERIOD, 32'd8);
        xfer();
        trig(1'b0);
        waitAct(1'b1, 60, n);
        scan(cnt, c3);
        chk(48'(cnt), 48'd34);
        trig(1'b1);
        waitAct(1'b0, 10, n);
    endtask : sineBurst

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        resetVals();
        memAccess();
        dcPath();
        trigDelay();
        pattern();
        sineBurst();
        test_done();
    end
endmodule : testbench
